/* File: src/fram_slave_defs.vh */
// Constants for the two-wire serial memory slave.
// Assumes inclusion by bare name from the design files under src/.
`ifndef FRAM_SLAVE_DEFS_VH
`define FRAM_SLAVE_DEFS_VH

// Array geometry
`define MEM_AW 13
`define MEM_DW 8
`define MEM_DEPTH 8192

// Device address byte fields
`define DEVB_TYPE_HI 7
`define DEVB_TYPE_LO 4
`define DEVB_SEL_HI 3
`define DEVB_SEL_LO 1
`define DEVB_RW 0

// Neutral device type code, value is arbitrary
`define DEV_TYPE_DEF 4'h5

// Bits per byte on the bus
`define BYTE_BITS 4'h8

// Reset value and default buffer depth
`define ADDR_RST 13'h0000
`define BUF_DEPTH_DEF 2

`endif

/* File: src/pin_sync.v */
// Two-flop synchroniser for pins from outside the sys_clk domain.
// Assumes the pins are asynchronous levels; reset is synchronous.
`timescale 1ns/100ps
module pin_sync
#(
    parameter W = 2
)
(
    input wire sys_clk,
    input wire rst_n,
    input wire [W-1:0] pin_in,
    output wire [W-1:0] pin_sync_out
);

reg [W-1:0] meta_ff;
reg [W-1:0] sync_ff;

// First stage feeds only the second stage
always @(posedge sys_clk)
begin
    if (!rst_n)
    begin
        meta_ff <= {W{1'b1}};
        sync_ff <= {W{1'b1}};
    end
    else
    begin
        meta_ff <= pin_in;
        sync_ff <= meta_ff;
    end
end

assign pin_sync_out = sync_ff;

endmodule

/* File: src/byte_buffer.v */
// Small FIFO with valid/ready on both sides, storage in flip-flops.
// Assumes both sides on sys_clk; synchronous active-low reset.
`timescale 1ns/100ps
module byte_buffer
#(
    parameter W = 21,
    parameter DEPTH = 2,
    parameter PW = 1
)
(
    input wire sys_clk,
    input wire rst_n,
    input wire in_valid,
    output wire in_ready,
    input wire [W-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [W-1:0] out_data
);

reg [W-1:0] mem_ff [0:DEPTH-1];
reg [PW-1:0] wr_ptr_ff;
reg [PW-1:0] rd_ptr_ff;
reg [PW:0] count_ff;
wire push;
wire pop;

// Pointer step with wrap at the depth
function [PW-1:0] ptr_inc;
    input [PW-1:0] p;
    begin
        if (p == DEPTH[PW-1:0] - 1'b1)
            ptr_inc = {PW{1'b0}};
        else
            ptr_inc = p + 1'b1;
    end
endfunction

// Honest full and empty
assign in_ready = (count_ff != DEPTH[PW:0]);
assign out_valid = (count_ff != {(PW+1){1'b0}});
assign push = in_valid & in_ready;
assign pop = out_valid & out_ready;
assign out_data = mem_ff[rd_ptr_ff];

// Storage write
always @(posedge sys_clk)
begin
    if (push)
        mem_ff[wr_ptr_ff] <= in_data;
end

// Pointers and fill count
always @(posedge sys_clk)
begin
    if (!rst_n)
    begin
        wr_ptr_ff <= {PW{1'b0}};
        rd_ptr_ff <= {PW{1'b0}};
        count_ff <= {(PW+1){1'b0}};
    end
    else
    begin
        if (push)
            wr_ptr_ff <= ptr_inc(wr_ptr_ff);
        if (pop)
            rd_ptr_ff <= ptr_inc(rd_ptr_ff);
        if (push & ~pop)
            count_ff <= count_ff + 1'b1;
        else if (pop & ~push)
            count_ff <= count_ff - 1'b1;
    end
end

endmodule

/* File: src/i2c_fram_slave.v */
// Two-wire serial slave in front of an 8K x 8 flip-flop array.
// Assumes scl/sda arrive asynchronously and the pad resolves the
// open-drain wire from sda_oe; sys_clk is far faster than scl.
`timescale 1ns/100ps
`include "fram_slave_defs.vh"
module i2c_fram_slave
#(
    parameter AW = `MEM_AW,
    parameter DW = `MEM_DW,
    parameter DEPTH = `MEM_DEPTH,
    parameter [3:0] DEV_TYPE = `DEV_TYPE_DEF,
    parameter BUF_DEPTH = `BUF_DEPTH_DEF
)
(
    input wire sys_clk,
    input wire rst_n,
    input wire scl_in,
    input wire sda_in,
    output wire sda_out,
    output wire sda_oe,
    input wire [2:0] chip_select_pins,
    input wire write_protect,
    input wire array_stall,
    output wire selected,
    output wire [AW-1:0] cur_addr
);

////////////////////////////////////////////////////////////////////////
// States, one-hot

localparam [5:0] ST_IDLE = 6'h01;
localparam [5:0] ST_DEV = 6'h02;
localparam [5:0] ST_AHI = 6'h04;
localparam [5:0] ST_ALO = 6'h08;
localparam [5:0] ST_WR = 6'h10;
localparam [5:0] ST_RD = 6'h20;

////////////////////////////////////////////////////////////////////////
// Declarations

reg [5:0] state_ff;
reg [5:0] nxt_state;
reg [3:0] bit_cnt_ff;
reg [3:0] nxt_bit_cnt;
reg ack_phase_ff;
reg nxt_ack_phase;
reg [DW-1:0] rx_ff;
reg [DW-1:0] nxt_rx;
reg [DW-1:0] tx_ff;
reg [DW-1:0] nxt_tx;
reg [4:0] addr_hi_ff;
reg [4:0] nxt_addr_hi;
reg [AW-1:0] addr_ff;
reg [AW-1:0] nxt_addr;
reg drive_ff;
reg nxt_drive;
reg accept_ff;
reg nxt_accept;
reg master_ack_ff;
reg nxt_master_ack;
reg scl_d_ff;
reg sda_d_ff;
reg [DW-1:0] array_ff [0:DEPTH-1];

wire [5:0] pins_s;
wire [2:0] cs_s;
wire wp_s;
wire scl_s;
wire sda_s;
wire scl_rise;
wire scl_fall;
wire start_seen;
wire stop_seen;
wire [DW-1:0] rx_byte;
wire dev_match;
wire buf_in_ready;
wire buf_out_valid;
wire [AW+DW-1:0] buf_out_data;
reg buf_push;

////////////////////////////////////////////////////////////////////////
// Pin sampling and bus condition detection

pin_sync #(.W(6)) u_pin_sync
(
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .pin_in({scl_in, sda_in, write_protect, chip_select_pins}),
    .pin_sync_out(pins_s)
);

assign scl_s = pins_s[5];
assign sda_s = pins_s[4];
assign wp_s = pins_s[3];
assign cs_s = pins_s[2:0];

// Previous synchronised levels for edge finding
always @(posedge sys_clk)
begin
    if (!rst_n)
    begin
        scl_d_ff <= 1'b1;
        sda_d_ff <= 1'b1;
    end
    else
    begin
        scl_d_ff <= scl_s;
        sda_d_ff <= sda_s;
    end
end

assign scl_rise = scl_s & ~scl_d_ff;
assign scl_fall = ~scl_s & scl_d_ff;
// Data edges while clock stays high
assign start_seen = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
assign stop_seen = scl_s & scl_d_ff & ~sda_d_ff & sda_s;

////////////////////////////////////////////////////////////////////////
// Byte assembly and address decode

// Bit taken on the rising clock, previous bits shifted up
assign rx_byte = {rx_ff[DW-2:0], sda_s};
assign dev_match = (rx_ff[`DEVB_TYPE_HI:`DEVB_TYPE_LO] == DEV_TYPE) &&
    (rx_ff[`DEVB_SEL_HI:`DEVB_SEL_LO] == cs_s);

// Write path buffer: address and data toward the array
byte_buffer #(.W(AW + DW), .DEPTH(BUF_DEPTH), .PW(1)) u_wr_buf
(
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .in_valid(buf_push),
    .in_ready(buf_in_ready),
    .in_data({addr_ff, rx_byte}),
    .out_valid(buf_out_valid),
    .out_ready(~array_stall),
    .out_data(buf_out_data)
);

// Array update as the buffer drains, well inside the byte time while array_stall is low
always @(posedge sys_clk)
begin
    if (buf_out_valid & ~array_stall)
        array_ff[buf_out_data[AW+DW-1:DW]] <= buf_out_data[DW-1:0];
end

////////////////////////////////////////////////////////////////////////
// Protocol engine, next-state logic

always @*
begin
    nxt_state = state_ff;
    nxt_bit_cnt = bit_cnt_ff;
    nxt_ack_phase = ack_phase_ff;
    nxt_rx = rx_ff;
    nxt_tx = tx_ff;
    nxt_addr_hi = addr_hi_ff;
    nxt_addr = addr_ff;
    nxt_drive = drive_ff;
    nxt_accept = accept_ff;
    nxt_master_ack = master_ack_ff;
    buf_push = 1'b0;
    if (start_seen)
    begin
        // Abort and expect a fresh device byte
        nxt_state = ST_DEV;
        nxt_bit_cnt = 4'h0;
        nxt_ack_phase = 1'b0;
        nxt_drive = 1'b0;
    end
    else if (stop_seen)
    begin
        // Abort to idle, line released
        nxt_state = ST_IDLE;
        nxt_bit_cnt = 4'h0;
        nxt_ack_phase = 1'b0;
        nxt_drive = 1'b0;
    end
    else
    begin
        case (state_ff)
            ST_IDLE:
            begin
                nxt_drive = 1'b0;
            end
            ST_DEV, ST_AHI, ST_ALO, ST_WR:
            begin
                if (scl_rise & ~ack_phase_ff & (bit_cnt_ff < `BYTE_BITS))
                begin
                    nxt_rx = rx_byte;
                    nxt_bit_cnt = bit_cnt_ff + 4'h1;
                    if (bit_cnt_ff == `BYTE_BITS - 4'h1)
                    begin
                        if (state_ff == ST_AHI)
                            nxt_addr_hi = rx_byte[4:0];
                        if (state_ff == ST_ALO)
                            nxt_addr = {addr_hi_ff, rx_byte};
                        if (state_ff == ST_WR)
                        begin
                            // Commit at the eighth bit unless protected or the buffer is full
                            nxt_accept = ~wp_s & buf_in_ready;
                            buf_push = ~wp_s & buf_in_ready;
                            if (~wp_s & buf_in_ready)
                                nxt_addr = addr_ff + 1'b1;
                        end
                    end
                end
                else if (scl_fall & ~ack_phase_ff & (bit_cnt_ff == `BYTE_BITS))
                begin
                    // Ninth clock: acknowledge or drop out
                    nxt_ack_phase = 1'b1;
                    if (state_ff == ST_DEV)
                    begin
                        nxt_drive = dev_match;
                        if (!dev_match)
                            nxt_state = ST_IDLE;
                    end
                    else if (state_ff == ST_WR)
                    begin
                        nxt_drive = accept_ff;
                        if (!accept_ff)
                            nxt_state = ST_IDLE;
                    end
                    else
                        nxt_drive = 1'b1;
                end
                else if (scl_fall & ack_phase_ff)
                begin
                    // Ack clock over, release and move on
                    nxt_ack_phase = 1'b0;
                    nxt_bit_cnt = 4'h0;
                    nxt_drive = 1'b0;
                    if (state_ff == ST_DEV)
                    begin
                        if (rx_ff[`DEVB_RW])
                        begin
                            // Read from the latched address
                            nxt_state = ST_RD;
                            nxt_tx = array_ff[addr_ff];
                            nxt_drive = ~array_ff[addr_ff][DW-1];
                        end
                        else
                            nxt_state = ST_AHI;
                    end
                    else if (state_ff == ST_AHI)
                        nxt_state = ST_ALO;
                    else
                        nxt_state = ST_WR;
                end
            end
            ST_RD:
            begin
                if (scl_rise & ~ack_phase_ff)
                    nxt_bit_cnt = bit_cnt_ff + 4'h1;
                else if (scl_rise & ack_phase_ff)
                    nxt_master_ack = ~sda_s;
                else if (scl_fall & ~ack_phase_ff)
                begin
                    if (bit_cnt_ff == `BYTE_BITS)
                    begin
                        // Byte shifted: release for master ack, advance
                        nxt_ack_phase = 1'b1;
                        nxt_drive = 1'b0;
                        nxt_addr = addr_ff + 1'b1;
                    end
                    else
                    begin
                        nxt_tx = {tx_ff[DW-2:0], 1'b0};
                        nxt_drive = ~tx_ff[DW-2];
                    end
                end
                else if (scl_fall & ack_phase_ff)
                begin
                    nxt_ack_phase = 1'b0;
                    nxt_bit_cnt = 4'h0;
                    if (master_ack_ff)
                    begin
                        // Next sequential byte
                        nxt_tx = array_ff[addr_ff];
                        nxt_drive = ~array_ff[addr_ff][DW-1];
                    end
                    else
                    begin
                        nxt_state = ST_IDLE;
                        nxt_drive = 1'b0;
                    end
                end
            end
            default:
            begin
                nxt_state = ST_IDLE;
                nxt_drive = 1'b0;
            end
        endcase
    end
end

////////////////////////////////////////////////////////////////////////
// Protocol engine registers

always @(posedge sys_clk)
begin
    if (!rst_n)
    begin
        state_ff <= ST_IDLE;
        bit_cnt_ff <= 4'h0;
        ack_phase_ff <= 1'b0;
        rx_ff <= {DW{1'b0}};
        tx_ff <= {DW{1'b0}};
        addr_hi_ff <= 5'h00;
        addr_ff <= `ADDR_RST;
        drive_ff <= 1'b0;
        accept_ff <= 1'b0;
        master_ack_ff <= 1'b0;
    end
    else
    begin
        state_ff <= nxt_state;
        bit_cnt_ff <= nxt_bit_cnt;
        ack_phase_ff <= nxt_ack_phase;
        rx_ff <= nxt_rx;
        tx_ff <= nxt_tx;
        addr_hi_ff <= nxt_addr_hi;
        addr_ff <= nxt_addr;
        drive_ff <= nxt_drive;
        accept_ff <= nxt_accept;
        master_ack_ff <= nxt_master_ack;
    end
end

////////////////////////////////////////////////////////////////////////
// Outputs

// Open-drain: only ever pulls low, never drives high
assign sda_out = 1'b0;
assign sda_oe = drive_ff;
assign selected = ~state_ff[0] & ~state_ff[1];
assign cur_addr = addr_ff;

endmodule

/* File: bench/i2c_master_model.sv */
// Two-wire bus master model.
// Assumes the bench forms a pulled-up data wire from sda_m.
`timescale 1ns/100ps
module i2c_master_model
(
    input wire sys_clk,
    input wire sda,
    output logic scl,
    output logic sda_m
);
////////////////////
// Both lines idle high
initial
begin
    scl = 1'b1;
    sda_m = 1'b1;
end
// Wait n clocks, step off the edge
task w(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
endtask
// Data falls with clock high
task start;
    sda_m = 1'b1;
    w(4);
    scl = 1'b1;
    w(3);
    sda_m = 1'b0;
    w(3);
    scl = 1'b0;
    w(1);
endtask
// Data rises with clock high
task stop;
    sda_m = 1'b0;
    w(4);
    scl = 1'b1;
    w(3);
    sda_m = 1'b1;
    w(4);
endtask
// Set while clock low, sample while high
task bit_x(input logic b, output logic s);
    w(2);
    sda_m = b;
    w(2);
    scl = 1'b1;
    w(2);
    s = sda;
    w(1);
    scl = 1'b0;
    w(1);
endtask
// Byte out, top bit first, then release
task wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
        bit_x(d[i], s);
    bit_x(1'b1, ack);
endtask
// Byte in, ack withheld on the last
task rbyte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
        bit_x(1'b1, d[i]);
    bit_x(last, s);
endtask
endmodule

/* File: bench/i2c_fram_slave_properties.sv */
// Checker on the slave's ports.
// Assumes pins arrive via the design's synchronisers.
`timescale 1ns/100ps
module i2c_fram_slave_properties
#(
    parameter AW = 13
)
(
    input wire sys_clk,
    input wire rst_n,
    input wire scl_in,
    input wire sda_in,
    input wire sda_out,
    input wire sda_oe,
    input wire selected,
    input wire [AW-1:0] cur_addr
);
default clocking cb @(posedge sys_clk); endclocking
default disable iff (!rst_n);
logic [6:0] oe_run_ff;
////////////////////
// Length of the current drive run
always @(posedge sys_clk)
begin
    if (!rst_n || !sda_oe)
        oe_run_ff <= 7'h00;
    else if (oe_run_ff != 7'h7f)
        oe_run_ff <= oe_run_ff + 7'h01;
end
// Bus conditions on the pins
sequence s_start;
    scl_in && $past(scl_in) && $fell(sda_in);
endsequence
sequence s_stop;
    scl_in && $past(scl_in) && $rose(sda_in);
endsequence
property p_out_low;
    sda_out == 1'b0;
endproperty
a_out_low: assert property (p_out_low) else $error("data pin driven high");
property p_rst_clear;
    disable iff (1'b0) !rst_n |=> !sda_oe && !selected && cur_addr == {AW{1'b0}};
endproperty
a_rst_clear: assert property (p_rst_clear) else $error("reset left state");
property p_oe_on_low;
    $changed(sda_oe) |-> !scl_in && !$past(scl_in, 2);
endproperty
a_oe_on_low: assert property (p_oe_on_low) else $error("drive moved with clock high");
property p_start_new;
    s_start |-> ##[1:8] !selected;
endproperty
a_start_new: assert property (p_start_new) else $error("start did not restart");
property p_stop_idle;
    s_stop |-> ##[1:8] (!selected && !sda_oe) ##1 !selected [*4];
endproperty
a_stop_idle: assert property (p_stop_idle) else $error("stop did not idle");
property p_addr_hold;
    !selected && !$past(selected) |-> $stable(cur_addr);
endproperty
a_addr_hold: assert property (p_addr_hold) else $error("latch moved while idle");
property p_oe_len;
    oe_run_ff <= 7'h48;
endproperty
a_oe_len: assert property (p_oe_len) else $error("drive held too long");
property p_oe_unsel;
    $rose(sda_oe) && !selected |-> ##[1:12] (!sda_oe || selected);
endproperty
a_oe_unsel: assert property (p_oe_unsel) else $error("drive while unselected");
c_read: cover property (selected && $rose(sda_oe));
c_stop: cover property (s_stop);
c_wrap: cover property ($past(cur_addr) == {AW{1'b1}} && cur_addr == {AW{1'b0}});
endmodule
bind i2c_fram_slave i2c_fram_slave_properties #(.AW(AW)) props
(
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .selected(selected),
    .cur_addr(cur_addr)
);

/* File: bench/i2c_serial_fram_slave_8kx8_bench.sv */
// Self-checking bench for the two-wire memory slave.
// Assumes the master model and the bound checker.
`timescale 1ns/100ps
module i2c_serial_fram_slave_8kx8_bench;
localparam logic [3:0] TYPE = 4'h9; // Arbitrary type code
localparam logic [2:0] PINS = 3'h5;
logic sys_clk, rst_n, wp, stall, a;
logic [2:0] cs;
logic [7:0] d;
int err_count, compares;
wire scl, sda_m, sda_oe, sda_out, selected;
wire [12:0] cur_addr;
// Open-drain wire with pull-up
wire sda = sda_m & (sda_out | ~sda_oe);
////////////////////
i2c_fram_slave #(.DEV_TYPE(TYPE)) uut
(
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .scl_in(scl),
    .sda_in(sda),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .chip_select_pins(cs),
    .write_protect(wp),
    .array_stall(stall),
    .selected(selected),
    .cur_addr(cur_addr)
);
i2c_master_model m
(
    .sys_clk(sys_clk),
    .sda(sda),
    .scl(scl),
    .sda_m(sda_m)
);
// Compare and count
task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e)
    begin
        err_count++;
        $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
endtask
function automatic logic [7:0] dv(input logic rw);
    return {TYPE, PINS, rw};
endfunction
// Write device byte and two address bytes
task seta(input logic [15:0] ad);
    m.start;
    m.wbyte(dv(1'b0), a);
    chk("dev_ack", 0, a);
    m.wbyte(ad[15:8], a);
    chk("hi_ack", 0, a);
    m.wbyte(ad[7:0], a);
    chk("lo_ack", 0, a);
endtask
// Start and read device byte
task ropen;
    m.start;
    m.wbyte(dv(1'b1), a);
    chk("rd_ack", 0, a);
endtask
task rd1(input logic [7:0] e, input logic last);
    m.rbyte(last, d);
    chk("rdata", e, d);
endtask
// Write over the top of the array, read back
task t_wrap;
    seta(16'hfffe);
    chk("addr", 16'h1ffe, cur_addr);
    for (int i = 0; i < 3; i++)
    begin
        m.wbyte(8'ha1 + 8'h11 * i[7:0], a);
        chk("wr_ack", 0, a);
    end
    chk("addr", 16'h0001, cur_addr);
    seta(16'h1ffe);
    ropen;
    rd1(8'ha1, 1'b0);
    rd1(8'hb2, 1'b0);
    rd1(8'hc3, 1'b1);
    m.stop;
    chk("addr", 16'h0001, cur_addr);
endtask
// Wrong type code or select pins
task t_select;
    for (int k = 0; k < 8; k++)
    begin
        cs = PINS ^ k[2:0];
        m.start;
        m.wbyte(k == 0 ? {~TYPE, PINS, 1'b1} : dv(k[0]), a);
        chk("nack", 1, a);
        m.w(4);
        chk("sel", 0, selected);
        m.stop;
    end
    cs = PINS;
endtask
// Protected write refused
task t_protect;
    seta(16'h0010);
    m.wbyte(8'h55, a);
    m.stop;
    wp = 1'b1;
    seta(16'h0010);
    m.wbyte(8'haa, a);
    chk("wp_ack", 1, a);
    chk("addr", 16'h0010, cur_addr);
    m.stop;
    wp = 1'b0;
    ropen;
    rd1(8'h55, 1'b1);
    m.stop;
endtask
// Partial bytes cut by stop or start
task t_abort;
    seta(16'h0020);
    m.wbyte(8'h11, a);
    m.stop;
    seta(16'h0020);
    for (int i = 0; i < 4; i++)
        m.bit_x(1'b0, a);
    m.stop;
    chk("sel", 0, selected);
    m.start;
    m.wbyte(dv(1'b0), a);
    m.wbyte(8'h00, a);
    for (int i = 0; i < 3; i++)
        m.bit_x(1'b1, a);
    ropen;
    rd1(8'h11, 1'b1);
    m.stop;
endtask
// Stalled array: buffer fills, then drains
task t_buffer;
    stall = 1'b1;
    seta(16'h0040);
    for (int i = 0; i < 3; i++)
    begin
        m.wbyte(8'h40 + i[7:0], a);
        chk("buf_ack", i == 2, a);
    end
    chk("addr", 16'h0042, cur_addr);
    m.stop;
    stall = 1'b0;
    seta(16'h0040);
    ropen;
    rd1(8'h40, 1'b0);
    rd1(8'h41, 1'b1);
    m.stop;
endtask
task stop_test;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
        $display("bench passed");
    else
        $display("bench failed");
    $finish;
endtask
// Clock
initial
begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
end
// Reset, then the scenarios
initial
begin
    err_count = 0;
    compares = 0;
    rst_n = 1'b0;
    wp = 1'b0;
    stall = 1'b0;
    cs = PINS;
    repeat (12) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    chk("rst_oe", 0, sda_oe);
    repeat (3) @(posedge sys_clk);
    t_wrap;
    t_select;
    t_protect;
    t_abort;
    t_buffer;
    stop_test;
end
// Watchdog
initial
begin
    #400000;
    err_count++;
    stop_test;
end
endmodule
